// ==== src/mbxb_pkg.sv ====
package mbxb_pkg;

  // Core clock
  localparam int CORE_CLK_MHZ = 125;
  localparam int SYS_CLK_DIV  = 2;

  // Data path
  localparam int WORD_W = 32;
  localparam int LANES  = 4;
  localparam int QUAD_W = WORD_W * LANES;
  localparam int ADDR_W = 32;

  // Memory blocks and address layout
  localparam int NUM_BLOCKS  = 6;
  localparam int BLOCK_WORDS = 131072;
  localparam int BLOCK_AW    = 17;
  localparam int TGT_LSB     = BLOCK_AW;
  localparam int TGT_W       = 3;
  localparam int NUM_TGT     = NUM_BLOCKS + 1;
  localparam logic [TGT_W-1:0] TGT_UREG = 3'h6;

  // Universal register window
  localparam int UREG_WORDS = 32;
  localparam int UREG_AW    = 5;
  localparam logic [BLOCK_AW-1:0] CORE_UREG_WORDS = 17'h00010;
  localparam logic [BLOCK_AW-1:0] UREG_LIMIT      = 17'h00020;

  // Requesters; a lower index wins arbitration
  localparam int NUM_REQ = 4;
  localparam int REQ_SYS = 0;
  localparam int REQ_I   = 1;
  localparam int REQ_J   = 2;
  localparam int REQ_K   = 3;

  // Access size codes and word counts
  localparam logic [1:0] SZ_SINGLE = 2'h0;
  localparam logic [1:0] SZ_LONG   = 2'h1;
  localparam logic [1:0] SZ_QUAD   = 2'h2;
  localparam logic [2:0] CNT_NONE   = 3'h0;
  localparam logic [2:0] CNT_SINGLE = 3'h1;
  localparam logic [2:0] CNT_LONG   = 3'h2;
  localparam logic [2:0] CNT_QUAD   = 3'h4;

  function automatic logic [2:0] size_words(input logic [1:0] sz);
    case (sz)
      SZ_SINGLE: size_words = CNT_SINGLE;
      SZ_LONG:   size_words = CNT_LONG;
      SZ_QUAD:   size_words = CNT_QUAD;
      default:   size_words = CNT_NONE;
    endcase
  endfunction

  function automatic logic [BLOCK_AW-1:0] align_down(input logic [BLOCK_AW-1:0] word,
                                                     input logic [1:0]          sz);
    logic [BLOCK_AW-1:0] mask;
    mask       = BLOCK_AW'(size_words(sz)) - BLOCK_AW'(1);
    align_down = word & ~mask;
  endfunction

endpackage

// ==== src/mbxb_arbiter.sv ====
`timescale 1ns/10ps
module mbxb_arbiter
  import mbxb_pkg::*;
(
  // Requests and one-hot grant for one target
  input  wire logic [NUM_REQ-1:0] i_req,
  output logic      [NUM_REQ-1:0] o_gnt
);

  // Fixed order, system side first so the half-rate bus cannot starve
  always_comb begin
    o_gnt = '0;
    for (int r = 0; r < NUM_REQ; r++) begin
      if (i_req[r] && (o_gnt == '0)) begin
        o_gnt[r] = 1'h1;
      end
    end
  end

endmodule

// ==== src/mbxb_mem_block.sv ====
`timescale 1ns/10ps
module mbxb_mem_block
  import mbxb_pkg::*;
(
  // Clock
  input  wire logic                i_clk,
  // One access per cycle
  input  wire logic                i_en,
  input  wire logic                i_we,
  input  wire logic [BLOCK_AW-1:0] i_addr,
  input  wire logic [1:0]          i_size,
  input  wire logic [QUAD_W-1:0]   i_wdata,
  // Read data, one cycle after the access
  output logic      [QUAD_W-1:0]   o_rdata
);

  // Holds code and data alike; no reset on the array itself
  logic [WORD_W-1:0] mem [BLOCK_WORDS];
  logic [QUAD_W-1:0] next_rdata;

  // Word-indexed read lets an unaligned quad come out already realigned
  always_comb begin
    next_rdata = o_rdata;
    if (i_en && !i_we) begin
      for (int i = 0; i < LANES; i++) begin
        if (i < int'(size_words(i_size))) begin
          next_rdata[i*WORD_W +: WORD_W] = mem[i_addr + BLOCK_AW'(i)];
        end else begin
          next_rdata[i*WORD_W +: WORD_W] = '0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= next_rdata;
    if (i_en && i_we) begin
      for (int i = 0; i < LANES; i++) begin
        if (i < int'(size_words(i_size))) begin
          mem[i_addr + BLOCK_AW'(i)] <= i_wdata[i*WORD_W +: WORD_W];
        end
      end
    end
  end

endmodule

// ==== src/mbxb_crossbar.sv ====
`timescale 1ns/10ps
module mbxb_crossbar
  import mbxb_pkg::*;
(
  // Clock and reset
  input  wire logic                               i_clk,
  input  wire logic                               i_srst,
  // Requests: system side, instruction bus, first and second data bus
  input  wire logic [NUM_REQ-1:0]                 i_req,
  input  wire logic [NUM_REQ-1:0][ADDR_W-1:0]     i_addr,
  input  wire logic [NUM_REQ-1:0][1:0]            i_size,
  input  wire logic [NUM_REQ-1:0]                 i_we,
  input  wire logic [NUM_REQ-1:0][QUAD_W-1:0]     i_wdata,
  // Answers
  output logic      [NUM_REQ-1:0]                 o_ready,
  output logic      [NUM_REQ-1:0]                 o_rvalid,
  output logic      [NUM_REQ-1:0]                 o_err,
  output logic      [NUM_REQ-1:0][QUAD_W-1:0]     o_rdata,
  // High in the second core cycle of each system bus cycle
  output logic                                    o_sys_phase
);

  // Two slots per requester: the head waits for a grant, the second catches
  // the request that arrived while the head was held off
  logic [NUM_REQ-1:0][1:0]                        q_v;
  logic [NUM_REQ-1:0][1:0]                        next_q_v;
  logic [NUM_REQ-1:0][1:0][ADDR_W-1:0]            q_addr;
  logic [NUM_REQ-1:0][1:0][ADDR_W-1:0]            next_q_addr;
  logic [NUM_REQ-1:0][1:0][1:0]                   q_size;
  logic [NUM_REQ-1:0][1:0][1:0]                   next_q_size;
  logic [NUM_REQ-1:0][1:0]                        q_we;
  logic [NUM_REQ-1:0][1:0]                        next_q_we;
  logic [NUM_REQ-1:0][1:0][QUAD_W-1:0]            q_wdata;
  logic [NUM_REQ-1:0][1:0][QUAD_W-1:0]            next_q_wdata;
  logic [NUM_REQ-1:0]                             next_ready;
  logic                                           next_sys_phase;

  // Head decode and arbitration
  logic [NUM_REQ-1:0]                             head_err;
  logic [NUM_REQ-1:0][TGT_W-1:0]                  head_tgt;
  logic [NUM_REQ-1:0]                             issue_ok;
  logic [NUM_REQ-1:0]                             granted;
  logic [NUM_REQ-1:0]                             pop;
  logic [NUM_REQ-1:0]                             push;
  logic [NUM_TGT-1:0][NUM_REQ-1:0]                arb_req;
  logic [NUM_TGT-1:0][NUM_REQ-1:0]                arb_gnt;

  // Per-target access, after the crossbar
  logic [NUM_TGT-1:0]                             tgt_en;
  logic [NUM_TGT-1:0]                             tgt_we;
  logic [NUM_TGT-1:0][1:0]                        tgt_size;
  logic [NUM_TGT-1:0][BLOCK_AW-1:0]               tgt_word;
  logic [NUM_TGT-1:0][QUAD_W-1:0]                 tgt_wdata;
  logic [NUM_BLOCKS-1:0][QUAD_W-1:0]              mem_rdata;

  // Universal register window
  logic [UREG_WORDS-1:0][WORD_W-1:0]              ureg;
  logic [UREG_WORDS-1:0][WORD_W-1:0]              next_ureg;
  logic [QUAD_W-1:0]                              ureg_rdata;
  logic [QUAD_W-1:0]                              next_ureg_rdata;
  logic [UREG_AW-1:0]                             ureg_idx;

  // Access stage to answer stage
  logic [NUM_REQ-1:0]                             s1_v;
  logic [NUM_REQ-1:0]                             s1_err;
  logic [NUM_REQ-1:0]                             s1_we;
  logic [NUM_REQ-1:0][TGT_W-1:0]                  s1_tgt;
  logic [NUM_REQ-1:0]                             next_rvalid;
  logic [NUM_REQ-1:0]                             next_err;
  logic [NUM_REQ-1:0][QUAD_W-1:0]                 next_rdata;

  function automatic logic req_bad(input int                r,
                                   input logic [ADDR_W-1:0] addr,
                                   input logic [1:0]        sz);
    logic [TGT_W-1:0]    tgt;
    logic [BLOCK_AW-1:0] word;
    tgt     = addr[TGT_LSB +: TGT_W];
    word    = addr[BLOCK_AW-1:0];
    req_bad = (|addr[ADDR_W-1:TGT_LSB+TGT_W]) || (size_words(sz) == CNT_NONE) || (tgt > TGT_UREG);
    if (tgt == TGT_UREG) begin
      // Register moves from the system side see the whole window; core loads and
      // stores must start in its core part (an unaligned load may run past it); fetch never reaches it
      if (r == REQ_I) begin
        req_bad = 1'h1;
      end
      if (((r == REQ_J) || (r == REQ_K)) && (word >= CORE_UREG_WORDS)) begin
        req_bad = 1'h1;
      end
      if (word >= UREG_LIMIT) begin
        req_bad = 1'h1;
      end
    end
  endfunction

  // Data-bus loads keep their own start word so an unaligned quad arrives
  // realigned; everything else is forced onto its natural boundary
  function automatic logic [BLOCK_AW-1:0] word_base(input int                  r,
                                                    input logic [BLOCK_AW-1:0] word,
                                                    input logic [1:0]          sz,
                                                    input logic                we);
    if (((r == REQ_J) || (r == REQ_K)) && !we) begin
      word_base = word;
    end else begin
      word_base = align_down(word, sz);
    end
  endfunction

  // Head decode: the system head may only issue in the first core cycle of
  // its slow cycle, which keeps its answers on slow-cycle boundaries
  always_comb begin
    for (int r = 0; r < NUM_REQ; r++) begin
      head_tgt[r] = q_addr[r][0][TGT_LSB +: TGT_W];
      head_err[r] = req_bad(r, q_addr[r][0], q_size[r][0]);
      issue_ok[r] = q_v[r][0] && ((r != REQ_SYS) || !o_sys_phase);
    end
    for (int t = 0; t < NUM_TGT; t++) begin
      for (int r = 0; r < NUM_REQ; r++) begin
        arb_req[t][r] = issue_ok[r] && !head_err[r] && (head_tgt[r] == TGT_W'(t));
      end
    end
  end

  // One arbiter per target, so distinct targets never wait on each other
  for (genvar t = 0; t < NUM_TGT; t++) begin : g_arb
    mbxb_arbiter u_arb (
      .i_req (arb_req[t]),
      .o_gnt (arb_gnt[t])
    );
  end

  // Crossbar: route the winning head onto each target
  always_comb begin
    granted = '0;
    for (int t = 0; t < NUM_TGT; t++) begin
      tgt_en[t]    = |arb_gnt[t];
      tgt_we[t]    = 1'h0;
      tgt_size[t]  = SZ_SINGLE;
      tgt_word[t]  = '0;
      tgt_wdata[t] = '0;
      for (int r = 0; r < NUM_REQ; r++) begin
        if (arb_gnt[t][r]) begin
          granted[r]   = 1'h1;
          tgt_we[t]    = q_we[r][0];
          tgt_size[t]  = q_size[r][0];
          tgt_word[t]  = word_base(r, q_addr[r][0][BLOCK_AW-1:0], q_size[r][0], q_we[r][0]);
          tgt_wdata[t] = q_wdata[r][0];
        end
      end
    end
    for (int r = 0; r < NUM_REQ; r++) begin
      pop[r] = granted[r] || (issue_ok[r] && head_err[r]);
    end
  end

  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    mbxb_mem_block u_mem (
      .i_clk   (i_clk),
      .i_en    (tgt_en[b]),
      .i_we    (tgt_we[b]),
      .i_addr  (tgt_word[b]),
      .i_size  (tgt_size[b]),
      .i_wdata (tgt_wdata[b]),
      .o_rdata (mem_rdata[b])
    );
  end

  // Register window sits in the same pipeline slot as a block, so register
  // moves complete with memory timing
  always_comb begin
    next_ureg       = ureg;
    next_ureg_rdata = ureg_rdata;
    ureg_idx        = '0;
    if (tgt_en[NUM_BLOCKS]) begin
      for (int i = 0; i < LANES; i++) begin
        ureg_idx = tgt_word[NUM_BLOCKS][UREG_AW-1:0] + UREG_AW'(i);
        if (i >= int'(size_words(tgt_size[NUM_BLOCKS]))) begin
          if (!tgt_we[NUM_BLOCKS]) begin
            next_ureg_rdata[i*WORD_W +: WORD_W] = '0;
          end
        end else if (tgt_we[NUM_BLOCKS]) begin
          next_ureg[ureg_idx] = tgt_wdata[NUM_BLOCKS][i*WORD_W +: WORD_W];
        end else begin
          next_ureg_rdata[i*WORD_W +: WORD_W] = ureg[ureg_idx];
        end
      end
    end
  end

  // Queues: pop the head, then append; ready promises room for one more
  always_comb begin
    next_q_v       = q_v;
    next_q_addr    = q_addr;
    next_q_size    = q_size;
    next_q_we      = q_we;
    next_q_wdata   = q_wdata;
    next_ready     = o_ready;
    next_sys_phase = !o_sys_phase;
    for (int r = 0; r < NUM_REQ; r++) begin
      push[r] = i_req[r] && o_ready[r] && ((r != REQ_SYS) || o_sys_phase);
      if (pop[r]) begin
        next_q_v[r]        = {1'h0, q_v[r][1]};
        next_q_addr[r][0]  = q_addr[r][1];
        next_q_size[r][0]  = q_size[r][1];
        next_q_we[r][0]    = q_we[r][1];
        next_q_wdata[r][0] = q_wdata[r][1];
      end
      if (push[r]) begin
        if (next_q_v[r][0]) begin
          next_q_v[r][1]     = 1'h1;
          next_q_addr[r][1]  = i_addr[r];
          next_q_size[r][1]  = i_size[r];
          next_q_we[r][1]    = i_we[r];
          next_q_wdata[r][1] = i_wdata[r];
        end else begin
          next_q_v[r][0]     = 1'h1;
          next_q_addr[r][0]  = i_addr[r];
          next_q_size[r][0]  = i_size[r];
          next_q_we[r][0]    = i_we[r];
          next_q_wdata[r][0] = i_wdata[r];
        end
      end
      // A held-off head stays in slot 0 and retries on the next cycle
      if ((r != REQ_SYS) || o_sys_phase) begin
        next_ready[r] = !next_q_v[r][1];
      end
    end
  end

  // Answer stage; system answers change only on slow-cycle boundaries and
  // therefore stand for two core cycles
  always_comb begin
    next_rvalid = o_rvalid;
    next_err    = o_err;
    next_rdata  = o_rdata;
    for (int r = 0; r < NUM_REQ; r++) begin
      if ((r != REQ_SYS) || o_sys_phase) begin
        next_rvalid[r] = s1_v[r];
        next_err[r]    = s1_v[r] && s1_err[r];
        next_rdata[r]  = '0;
        if (s1_v[r] && !s1_err[r] && !s1_we[r]) begin
          if (s1_tgt[r] == TGT_UREG) begin
            next_rdata[r] = ureg_rdata;
          end else begin
            next_rdata[r] = mem_rdata[s1_tgt[r]];
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    q_addr     <= next_q_addr;
    q_size     <= next_q_size;
    q_we       <= next_q_we;
    q_wdata    <= next_q_wdata;
    ureg_rdata <= next_ureg_rdata;
    s1_err     <= head_err;
    s1_we      <= tgt_we_of_head(q_we);
    s1_tgt     <= head_tgt;
    if (i_srst) begin
      q_v         <= '0;
      o_ready     <= '0;
      o_sys_phase <= 1'h0;
      ureg        <= '0;
      s1_v        <= '0;
      o_rvalid    <= '0;
      o_err       <= '0;
      o_rdata     <= '0;
    end else begin
      q_v         <= next_q_v;
      o_ready     <= next_ready;
      o_sys_phase <= next_sys_phase;
      ureg        <= next_ureg;
      s1_v        <= pop;
      o_rvalid    <= next_rvalid;
      o_err       <= next_err;
      o_rdata     <= next_rdata;
    end
  end

  function automatic logic [NUM_REQ-1:0] tgt_we_of_head(input logic [NUM_REQ-1:0][1:0] we);
    for (int r = 0; r < NUM_REQ; r++) begin
      tgt_we_of_head[r] = we[r][0];
    end
  endfunction

endmodule

// ==== verification/mbxb_crossbar_sva.sv ====
`timescale 1ns/10ps
module mbxb_crossbar_sva
  import mbxb_pkg::*;
(
  // Clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_srst,
  // Requests
  input  wire logic [NUM_REQ-1:0]             i_req,
  // Answers
  input  wire logic [NUM_REQ-1:0]             o_ready,
  input  wire logic [NUM_REQ-1:0]             o_rvalid,
  input  wire logic [NUM_REQ-1:0]             o_err,
  input  wire logic [NUM_REQ-1:0][QUAD_W-1:0] o_rdata,
  input  wire logic                           o_sys_phase
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_reset_quiet: assert property (disable iff (1'h0) i_srst |=>
    o_ready == '0 && o_rvalid == '0 && o_err == '0 && !o_sys_phase) else $error("outputs active in reset");
  a_phase_toggle: assert property (1'h1 |=> o_sys_phase != $past(o_sys_phase))
    else $error("system phase did not toggle");
  a_ready_up: assert property ($fell(i_srst) |-> ##1 o_ready[3:1] == 3'h7)
    else $error("core ready not up after reset");
  a_fetch_answer: assert property (i_req[1] && o_ready[1] |-> ##[3:1000] o_rvalid[1])
    else $error("instruction bus request unanswered");
  a_data_answer: assert property (i_req[3] && o_ready[3] |-> ##[3:1000] o_rvalid[3])
    else $error("second data bus request unanswered");
  a_sys_answer: assert property (o_sys_phase && i_req[0] && o_ready[0] |-> ##[3:1000] o_rvalid[0])
    else $error("system request unanswered");
  a_sys_slow: assert property (!o_sys_phase |=>
    $stable(o_rvalid[0]) && $stable(o_ready[0]) && $stable(o_rdata[0])) else $error("system answer moved mid slow cycle");
  a_err_qual: assert property ((o_err & ~o_rvalid) == '0)
    else $error("error without valid");
  a_err_zero: assert property (o_err[2] |-> o_rdata[2] == '0)
    else $error("refused access returned data");
  a_rdata_quiet: assert property (!o_rvalid[1] |-> o_rdata[1] == '0)
    else $error("read data shown without valid");
endmodule

bind mbxb_crossbar mbxb_crossbar_sva u_sva (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .o_ready(o_ready),
  .o_rvalid(o_rvalid), .o_err(o_err), .o_rdata(o_rdata), .o_sys_phase(o_sys_phase));

// ==== verification/mbxb_req_agent.sv ====
`timescale 1ns/10ps
module mbxb_req_agent
  import mbxb_pkg::*;
#(
  parameter bit IS_SYS = 1'h0
)
(
  // Clock and answers
  input  wire logic              i_clk,
  input  wire logic              i_ready,
  input  wire logic              i_rvalid,
  input  wire logic              i_err,
  input  wire logic [QUAD_W-1:0] i_rdata,
  input  wire logic              i_phase,
  // Request
  output logic                   o_req,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [1:0]        o_size,
  output logic                   o_we,
  output logic      [QUAD_W-1:0] o_wdata
);
  initial begin
    o_req = 1'h0;
    o_addr = '1;
    o_size = 2'h3;
    o_we = 1'h0;
    o_wdata = '1;
  end

  task automatic xfer(input logic [ADDR_W-1:0] a, input logic [1:0] s, input logic w,
                      input logic [QUAD_W-1:0] d, output logic [QUAD_W-1:0] q, output logic e, output int l);
    l = 0;
    @(negedge i_clk);
    // System side raises in phase 0 so the request spans a whole slow cycle
    while (!i_ready || (IS_SYS && i_phase)) @(negedge i_clk);
    o_req = 1'h1;
    o_addr = a;
    o_size = s;
    o_we = w;
    o_wdata = d;
    @(posedge i_clk);
    if (IS_SYS) @(posedge i_clk);
    @(negedge i_clk);
    // Released lines show the inverse so stale values never pass by luck
    o_req = 1'h0;
    o_addr = ~a;
    o_size = ~s;
    o_we = ~w;
    o_wdata = ~d;
    while (!i_rvalid && l < 200) begin
      @(negedge i_clk);
      l++;
    end
    q = i_rdata;
    e = i_err;
  endtask
endmodule

// ==== verification/test_multiblock_memory_crossbar.sv ====
`timescale 1ns/10ps
module test_multiblock_memory_crossbar
  import mbxb_pkg::*;
;
  logic                             i_clk;
  logic                             i_srst;
  wire logic [NUM_REQ-1:0]          i_req;
  wire logic [NUM_REQ-1:0][ADDR_W-1:0] i_addr;
  wire logic [NUM_REQ-1:0][1:0]     i_size;
  wire logic [NUM_REQ-1:0]          i_we;
  wire logic [NUM_REQ-1:0][QUAD_W-1:0] i_wdata;
  logic      [NUM_REQ-1:0]          o_ready;
  logic      [NUM_REQ-1:0]          o_rvalid;
  logic      [NUM_REQ-1:0]          o_err;
  logic      [NUM_REQ-1:0][QUAD_W-1:0] o_rdata;
  logic                             o_sys_phase;
  int                               err_count;
  int                               compares;
  logic      [QUAD_W-1:0]           q;
  logic                             e;
  int                               l;

  mbxb_crossbar u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .i_addr(i_addr), .i_size(i_size),
    .i_we(i_we), .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid), .o_err(o_err),
    .o_rdata(o_rdata), .o_sys_phase(o_sys_phase));

  for (genvar g = 0; g < NUM_REQ; g++) begin : g_ag
    mbxb_req_agent #(.IS_SYS(g == REQ_SYS)) u_ag (.i_clk(i_clk), .i_ready(o_ready[g]), .i_rvalid(o_rvalid[g]),
      .i_err(o_err[g]), .i_rdata(o_rdata[g]), .i_phase(o_sys_phase), .o_req(i_req[g]), .o_addr(i_addr[g]),
      .o_size(i_size[g]), .o_we(i_we[g]), .o_wdata(i_wdata[g]));
  end

  function automatic logic [ADDR_W-1:0] ad(input logic [2:0] b, input logic [16:0] w);
    ad = {12'h0, b, w};
  endfunction

  // Lane n carries n, top byte carries the block so misrouting shows
  function automatic logic [QUAD_W-1:0] dat(input int b);
    dat = {4{8'(b), 24'h0}} | {32'h3, 32'h2, 32'h1, 32'h0};
  endfunction

  task automatic chk(input logic [QUAD_W-1:0] seen, input logic [QUAD_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input int r, input logic [ADDR_W-1:0] a, input logic [1:0] s, input logic w,
                     input logic [QUAD_W-1:0] d);
    case (r)
      0: g_ag[0].u_ag.xfer(a, s, w, d, q, e, l);
      1: g_ag[1].u_ag.xfer(a, s, w, d, q, e, l);
      2: g_ag[2].u_ag.xfer(a, s, w, d, q, e, l);
      default: g_ag[3].u_ag.xfer(a, s, w, d, q, e, l);
    endcase
    // An answer that never came counts against the run
    chk(128'(l < 200), 128'h1);
  endtask

  task automatic t_blocks();
    for (int b = 0; b < NUM_BLOCKS; b++) begin
      acc(REQ_J, ad(3'(b), 17'h1fffc), SZ_QUAD, 1'h1, dat(b));
      chk(128'(e), 128'h0);
      for (int r = 0; r < NUM_REQ; r++) begin
        acc(r, ad(3'(b), 17'h1fffc), SZ_QUAD, 1'h0, ~dat(b));
        chk(q, dat(b));
      end
    end
  endtask

  task automatic t_sizes();
    logic [QUAD_W-1:0] m;
    acc(REQ_K, ad(3'h1, 17'h0), SZ_QUAD, 1'h1, {32'h3, 32'h2, 32'h1, 32'h0});
    acc(REQ_K, ad(3'h1, 17'h4), SZ_QUAD, 1'h1, {32'h7, 32'h6, 32'h5, 32'h4});
    acc(REQ_J, ad(3'h1, 17'h5), SZ_SINGLE, 1'h1, {96'hffff, 32'h55});
    for (int s = 0; s < 3; s++) begin
      m = (128'h1 << (32 * (1 << s))) - 128'h1;
      acc(REQ_K, ad(3'h1, 17'h2), 2'(s), 1'h0, '0);
      chk(q & m, {32'h55, 32'h4, 32'h3, 32'h2} & m);
    end
    acc(REQ_I, ad(3'h1, 17'h2), SZ_QUAD, 1'h0, '0);
    chk(q, {32'h3, 32'h2, 32'h1, 32'h0});
    acc(REQ_I, ad(3'h1, 17'h4), SZ_QUAD, 1'h0, '0);
    chk(q, {32'h7, 32'h6, 32'h55, 32'h4});
  endtask

  task automatic t_errors();
    int                rq [5] = '{REQ_J, REQ_J, REQ_K, REQ_I, REQ_J};
    logic [1:0]        bs [5] = '{2'h3, SZ_SINGLE, SZ_SINGLE, SZ_SINGLE, SZ_SINGLE};
    logic [ADDR_W-1:0] ba [5];
    ba = '{ad(3'h2, 17'h1fffc), ad(3'h7, 17'h0), 32'h00100000, ad(TGT_UREG, 17'h0), ad(TGT_UREG, 17'h10)};
    for (int i = 0; i < 5; i++) begin
      acc(rq[i], ba[i], bs[i], 1'h1, '1);
      chk(128'(e), 128'h1);
    end
    acc(REQ_I, ad(3'h2, 17'h1fffc), SZ_QUAD, 1'h0, '0);
    chk(q, dat(2));
    acc(REQ_J, ad(TGT_UREG, 17'h3), SZ_SINGLE, 1'h1, 128'h1234);
    acc(REQ_K, ad(TGT_UREG, 17'h3), SZ_SINGLE, 1'h0, '0);
    chk(q[31:0], 32'h1234);
    chk(128'(l), 128'h2);
    acc(REQ_SYS, ad(TGT_UREG, 17'h14), SZ_SINGLE, 1'h1, 128'h5678);
    acc(REQ_SYS, ad(TGT_UREG, 17'h14), SZ_SINGLE, 1'h0, '0);
    chk(q[31:0], 32'h5678);
  endtask

  task automatic t_conflict();
    logic [QUAD_W-1:0] q0, q1, q2, q3;
    logic              e0, e1, e2, e3;
    int                l0, l1, l2, l3;
    fork
      g_ag[2].u_ag.xfer(ad(3'h2, 17'h1fffc), SZ_QUAD, 1'h0, '0, q2, e2, l2);
      g_ag[3].u_ag.xfer(ad(3'h2, 17'h1fffc), SZ_QUAD, 1'h0, '0, q3, e3, l3);
    join
    chk(128'(l2), 128'h2);
    chk(128'(l3), 128'h3);
    chk(q3, dat(2));
    chk(q2, dat(2));
    fork
      g_ag[0].u_ag.xfer(ad(3'h0, 17'h8), SZ_QUAD, 1'h1, 128'h9abc, q0, e0, l0);
      g_ag[1].u_ag.xfer(ad(3'h3, 17'h1fffc), SZ_QUAD, 1'h0, '0, q1, e1, l1);
      g_ag[2].u_ag.xfer(ad(3'h4, 17'h1fffc), SZ_QUAD, 1'h0, '0, q2, e2, l2);
      g_ag[3].u_ag.xfer(ad(3'h5, 17'h1fffc), SZ_QUAD, 1'h0, '0, q3, e3, l3);
    join
    chk(128'(l0 < 200), 128'h1);
    chk(128'(e0), 128'h0);
    chk(128'(l1), 128'h2);
    chk(128'(l2), 128'h2);
    chk(128'(l3), 128'h2);
    chk(q1, dat(3));
    chk(q2, dat(4));
    chk(q3, dat(5));
    acc(REQ_I, ad(3'h0, 17'h8), SZ_QUAD, 1'h0, '0);
    chk(q, 128'h9abc);
  endtask

  task automatic rst();
    i_srst = 1'h1;
    // Count rising edges: the clock's first step to low may already be gone
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'h0;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    print_verdict();
  end

  initial begin
    err_count = 0;
    compares = 0;
    rst();
    t_blocks();
    t_sizes();
    t_errors();
    t_conflict();
    // Memory contents survive a second reset
    rst();
    acc(REQ_J, ad(3'h4, 17'h1fffc), SZ_QUAD, 1'h0, '0);
    chk(q, dat(4));
    print_verdict();
  end
endmodule
